//--- logic/dds_timing_pkg.sv
package dds_timing_pkg;
  localparam int WORD_W           = 40;
  localparam int BYTE_W           = 8;
  localparam int BYTES_PER_WORD   = 5;
  localparam int FREQ_LAT_CYC     = 18;
  localparam int PHASE_LAT_CYC    = 13;
  localparam int RESET_MIN_CYC    = 5;
  localparam int RESET_RECOV_CYC  = 2;
  localparam int RESET_OUT_CYC    = 13;
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int WAKE_US          = 5;
  localparam int WAKE_CYC         = (WAKE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REF_LOSS_CYC     = 64;
  localparam int CNT_W            = 16;
  localparam int FREQ_LSB         = 0;
  localparam int FREQ_W           = 32;
  localparam int CTRL_LSB         = 32;
  localparam int PHASE_LSB        = 35;
  localparam int PHASE_W          = 5;
  localparam int PDN_BIT          = 34;
  localparam int MULT_BIT         = 32;
  localparam logic [WORD_W-1:0] WORD_RST = 40'h00_0000_0000;
  typedef enum logic [1:0] {ST_RUN, ST_RESET, ST_RECOVER, ST_SLEEP} core_state_t;
endpackage

//--- logic/edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Only sync_q reads the first stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
endmodule

//--- logic/dds_update_reset_timing.sv
`timescale 1ns/1ps
// What the document requires
// RQ1 - Frequency changes 18 cycles, phase 13 cycles, after update strobe rises.
// RQ2 - Controller holds reset at least 5 system cycles to be accepted.
// RQ3 - After reset release, 2 recovery cycles pass before normal operation.
// RQ4 - Output shows reset condition 13 cycles after reset is applied. Code clears outputs 18 cycles after reset is applied.
// RQ5 - Leaving power-down, valid operation resumes after about 5 microseconds.
// RQ6 - Strobes and reset arrive asynchronously; acted on only with reference running.
// RQ7 - Missing reference clock forces power-down until the reference returns.
// RQ8 - Controller syncs fast back-to-back strobes to the reference clock.
// RQ9 - Each word-load rising edge shifts one byte into the 40-bit input register.
// RQ10 - Update rising edge moves the whole input register to the synthesis core.
// RQ11 - Controller updates only when the input register holds complete valid data.
// RQ12 - System clock is reference or multiplied reference; counts use it. Code counts reference rises only, even with MULT_BIT set.
// RQ13 - Controller waits out update latency before relying on new output.
module dds_update_reset_timing
  import dds_timing_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int LOSS_CYCLES = REF_LOSS_CYC
) (
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  input  wire logic                             reference_clock_in,
  input  wire logic                             word_load_strobe,
  input  wire logic                             frequency_update_strobe,
  input  wire logic                             dds_reset,
  input  wire logic [dds_timing_pkg::BYTE_W-1:0] data_in,
  output logic [dds_timing_pkg::FREQ_W-1:0]     freq_out,
  output logic [dds_timing_pkg::PHASE_W-1:0]    phase_out,
  output logic                                  mult_en_out,
  output logic                                  powered_down,
  output logic                                  ready
);
  import dds_timing_pkg::*;

  logic rst_m_q;
  logic rst_s_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Reference clock and strobes all cross in through two flops
  // Edges matter for clock and strobes, only the level for reset
  logic ref_rise;
  logic wl_rise;
  logic up_rise;
  logic rs_lvl;
  edge_sync u_ref (.core_clk(core_clk), .rst_n(rst_s_q), .async_in(reference_clock_in),
                   .level(), .rise(ref_rise));
  edge_sync u_wl  (.core_clk(core_clk), .rst_n(rst_s_q), .async_in(word_load_strobe),
                   .level(), .rise(wl_rise));
  edge_sync u_up  (.core_clk(core_clk), .rst_n(rst_s_q), .async_in(frequency_update_strobe),
                   .level(), .rise(up_rise));
  edge_sync u_rs  (.core_clk(core_clk), .rst_n(rst_s_q), .async_in(dds_reset),
                   .level(rs_lvl), .rise());

  // Data sampled late enough to have settled behind its strobe
  logic [BYTE_W-1:0] d_m_q, d_s_q, d_l_q;
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      d_m_q <= '0;
      d_s_q <= '0;
      d_l_q <= '0;
    end else begin
      d_m_q <= data_in;
      d_s_q <= d_m_q;
      d_l_q <= d_s_q;
    end
  end

  // Loss-of-reference watchdog in core cycles
  logic [CNT_W-1:0] loss_q;
  wire ref_lost = (loss_q >= CNT_W'(LOSS_CYCLES));
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) loss_q <= '0;
    else if (ref_rise) loss_q <= '0;
    else if (!ref_lost) loss_q <= loss_q + 1'b1;
  end

  // System clock tick: one per reference rising edge
  wire sys_tick = ref_rise; // RQ12

  core_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WORD_W-1:0] in_reg_q, act_q;
  logic [CNT_W-1:0] rs_width_q;
  logic [CNT_W-1:0] rs_out_q;
  logic [CNT_W-1:0] freq_cnt_q, phase_cnt_q;
  logic freq_pend_q, phase_pend_q;

  wire running   = (state_q == ST_RUN);
  wire rst_taken = rs_lvl && sys_tick && (rs_width_q == CNT_W'(RESET_MIN_CYC - 1)); // RQ2
  wire rst_fall  = !rs_lvl && (state_q == ST_RESET);

  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) rs_width_q <= '0;
    else if (!rs_lvl) rs_width_q <= '0;
    else if (sys_tick && rs_width_q != CNT_W'(RESET_MIN_CYC)) rs_width_q <= rs_width_q + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      state_q <= ST_SLEEP;
      cnt_q   <= '0;
    end else if (ref_lost) begin
      state_q <= ST_SLEEP; // RQ7
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_SLEEP: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(WAKE_CYCLES - 1)) state_q <= ST_RUN; // RQ5
        end
        ST_RUN: if (rst_taken) state_q <= ST_RESET;
        ST_RESET: if (rst_fall) begin
          state_q <= ST_RECOVER;
          cnt_q   <= '0;
        end
        ST_RECOVER: if (sys_tick) begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RESET_RECOV_CYC - 1)) state_q <= ST_RUN; // RQ3
        end
        default: state_q <= ST_SLEEP;
      endcase
    end
  end

  // Byte loads, ignored unless the core is up
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) in_reg_q <= WORD_RST;
    else if (state_q == ST_RESET) in_reg_q <= WORD_RST;
    else if (wl_rise && running) in_reg_q <= {d_l_q, in_reg_q[WORD_W-1:BYTE_W]}; // RQ9 RQ6
  end

  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) act_q <= WORD_RST;
    else if (up_rise && running) act_q <= in_reg_q; // RQ10 RQ6
  end

  // Latency pipes count system clock ticks, new update restarts them
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      freq_pend_q  <= 1'b0;
      phase_pend_q <= 1'b0;
      freq_cnt_q   <= '0;
      phase_cnt_q  <= '0;
    end else if (up_rise && running) begin
      freq_pend_q  <= 1'b1;
      phase_pend_q <= 1'b1;
      freq_cnt_q   <= '0;
      phase_cnt_q  <= '0;
    end else if (sys_tick) begin
      if (freq_pend_q) freq_cnt_q <= freq_cnt_q + 1'b1;
      if (phase_pend_q) phase_cnt_q <= phase_cnt_q + 1'b1;
      if (freq_cnt_q == CNT_W'(FREQ_LAT_CYC - 1)) freq_pend_q <= 1'b0;
      if (phase_cnt_q == CNT_W'(PHASE_LAT_CYC - 1)) phase_pend_q <= 1'b0;
    end
  end

  wire freq_apply  = sys_tick && freq_pend_q && freq_cnt_q == CNT_W'(FREQ_LAT_CYC - 1);
  wire phase_apply = sys_tick && phase_pend_q && phase_cnt_q == CNT_W'(PHASE_LAT_CYC - 1);

  // Reset output latency counter
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) rs_out_q <= '0;
    else if (state_q != ST_RESET) rs_out_q <= '0;
    else if (sys_tick && rs_out_q != CNT_W'(RESET_OUT_CYC)) rs_out_q <= rs_out_q + 1'b1;
  end
  wire rst_show = sys_tick && (state_q == ST_RESET) && rs_out_q == CNT_W'(RESET_OUT_CYC - 1);

  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      freq_out    <= '0;
      phase_out   <= '0;
      mult_en_out <= 1'b0;
    end else if (rst_show || state_q == ST_SLEEP) begin
      freq_out    <= '0; // RQ4
      phase_out   <= '0;
      mult_en_out <= 1'b0;
    end else begin
      if (freq_apply) begin
        freq_out    <= act_q[FREQ_LSB +: FREQ_W]; // RQ1
        mult_en_out <= act_q[MULT_BIT];
      end
      if (phase_apply) phase_out <= act_q[PHASE_LSB +: PHASE_W]; // RQ1
    end
  end

  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      powered_down <= 1'b1;
      ready        <= 1'b0;
    end else begin
      powered_down <= (state_q == ST_SLEEP) || ref_lost; // RQ7
      ready        <= running && !ref_lost; // RQ3
    end
  end

  // Assertions
  logic [CNT_W-1:0] tick_since_up_q;
  always_ff @(posedge core_clk or negedge rst_s_q) begin
    if (!rst_s_q) tick_since_up_q <= '0;
    else if (up_rise && running) tick_since_up_q <= '0;
    else if (sys_tick && tick_since_up_q != '1) tick_since_up_q <= tick_since_up_q + 1'b1;
  end

  freq_latency_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ1
    freq_apply |-> tick_since_up_q == CNT_W'(FREQ_LAT_CYC - 1))
    else $error("frequency applied at wrong latency");
  phase_latency_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ1
    phase_apply |-> tick_since_up_q == CNT_W'(PHASE_LAT_CYC - 1))
    else $error("phase applied at wrong latency");
  reset_width_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ2
    (running ##1 state_q == ST_RESET) |-> $past(rs_width_q) == CNT_W'(RESET_MIN_CYC - 1))
    else $error("reset accepted too early");
  recover_len_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ3
    ($rose(running) && $past(state_q) == ST_RECOVER) |-> $past(cnt_q) == CNT_W'(RESET_RECOV_CYC - 1))
    else $error("recovery length wrong");
  reset_out_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ4
    rst_show |=> freq_out == '0 && phase_out == '0)
    else $error("output not cleared after reset latency");
  sequence sleep_then_flag_s;
    state_q == ST_SLEEP ##1 powered_down;
  endsequence
  sleep_ref_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ7
    ref_lost |=> sleep_then_flag_s)
    else $error("no power-down on reference loss");
  load_gate_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ6
    (wl_rise && !running && state_q != ST_RESET) |=> $stable(in_reg_q))
    else $error("byte loaded while core down");
  update_copy_a: assert property (@(posedge core_clk) disable iff (!rst_s_q) // RQ10
    (up_rise && running) |=> act_q == $past(in_reg_q))
    else $error("update did not transfer input word");
endmodule

//--- verification/dds_ctrl_model.sv
`timescale 1ns/1ps
module dds_ctrl_model (
  output logic       reference_clock_in,
  output logic       word_load_strobe,
  output logic       frequency_update_strobe,
  output logic       dds_reset,
  output logic [7:0] data_in
);
  bit ref_on = 1'b1;
  initial begin
    reference_clock_in      = 1'b0;
    word_load_strobe        = 1'b0;
    frequency_update_strobe = 1'b0;
    dds_reset               = 1'b0;
    data_in                 = 8'h00;
  end
  // Stands low while stopped, no free-running edges
  always #62.5 reference_clock_in = ref_on & ~reference_clock_in;
  // Start in the low half so every strobe meets a clean cycle count
  task automatic align();
    if (ref_on) @(negedge reference_clock_in);
    #5;
  endtask
  task automatic load_byte(input logic [7:0] b);
    align();
    data_in = b;
    #40 word_load_strobe = 1'b1;
    #40 word_load_strobe = 1'b0;
    // Released bus shows the inverse, not a stale copy
    #40 data_in = ~b;
  endtask
  // Only issued once a whole word has gone in
  task automatic update();
    align();
    frequency_update_strobe = 1'b1;
    #40 frequency_update_strobe = 1'b0;
  endtask
  task automatic set_reset(input logic v);
    align();
    dds_reset = v;
  endtask
endmodule

//--- verification/dds_update_reset_timing_tb_top.sv
`timescale 1ns/1ps
module dds_update_reset_timing_tb_top;
  import dds_timing_pkg::*;
  logic               core_clk;
  logic               rst_n;
  logic [FREQ_W-1:0]  freq_out;
  logic [PHASE_W-1:0] phase_out;
  logic               mult_en_out, powered_down, ready;
  wire                ref_clk, wl_stb, up_stb, dres;
  wire  [BYTE_W-1:0]  din;
  int                 n_errors = 0, comparisons = 0;
  logic [7:0]         seed = 8'h5c, bq[$];
  logic [WORD_W-1:0]  act = '0;

  dds_update_reset_timing dut (
    .core_clk(core_clk), .rst_n(rst_n), .reference_clock_in(ref_clk),
    .word_load_strobe(wl_stb), .frequency_update_strobe(up_stb), .dds_reset(dres),
    .data_in(din), .freq_out(freq_out), .phase_out(phase_out),
    .mult_en_out(mult_en_out), .powered_down(powered_down), .ready(ready));
  dds_ctrl_model m (.reference_clock_in(ref_clk), .word_load_strobe(wl_stb),
    .frequency_update_strobe(up_stb), .dds_reset(dres), .data_in(din));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string what, input logic [WORD_W-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Frequency and multiplier from word f, phase from word p
  task automatic chk_out(input logic [WORD_W-1:0] f, p);
    chk("freq_out", {8'h00, f[FREQ_W-1:0]}, {8'h00, freq_out});
    chk("mult_en_out", 40'(f[MULT_BIT]), 40'(mult_en_out));
    chk("phase_out", 40'(p[WORD_W-1:PHASE_LSB]), 40'(phase_out));
  endtask
  task automatic rises(input int n);
    repeat (n) @(posedge ref_clk);
    #50;
  endtask
  task automatic wait_ready(input int lim);
    int k = 0;
    while (ready !== 1'b1 && k < lim) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk("ready", 40'h1, 40'(ready));
  endtask
  task automatic run_update(input int n);
    logic [WORD_W-1:0] nw;
    repeat (n) begin
      seed = lfsr(seed);
      bq.push_back(seed);
      m.load_byte(seed);
    end
    // Latest byte lands on top, older ones shift out
    nw = {bq[$], bq[$-1], bq[$-2], bq[$-3], bq[$-4]};
    m.update();
    rises(12);
    chk_out(act, act);
    rises(1);
    chk_out(act, nw);
    rises(4);
    chk_out(act, nw);
    rises(1);
    chk_out(nw, nw);
    act = nw;
    $display("update after %0d loads done", n);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Whole run needs well under 50 us
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk("powered_down", 40'h1, 40'(powered_down));
    wait_ready(WAKE_CYC + 75);
    for (int i = 0; i < 3; i++) run_update(5 + i);
    m.set_reset(1'b1);
    rises(4);
    m.set_reset(1'b0);
    rises(20);
    chk_out(act, act);
    chk("ready", 40'h1, 40'(ready));
    $display("short reset done");
    m.set_reset(1'b1);
    rises(12);
    chk_out(act, act);
    rises(8);
    chk_out('0, '0);
    m.set_reset(1'b0);
    rises(1);
    chk("ready", 40'h0, 40'(ready));
    rises(2);
    chk("ready", 40'h1, 40'(ready));
    bq.delete();
    act = '0;
    run_update(5);
    m.ref_on = 1'b0;
    // Loss is only declared after a full watchdog span without a rise
    repeat (REF_LOSS_CYC + 16) @(posedge core_clk);
    #1;
    chk("powered_down", 40'h1, 40'(powered_down));
    chk("ready", 40'h0, 40'(ready));
    chk_out('0, '0);
    repeat (5) m.load_byte(8'hff);
    m.update();
    m.ref_on = 1'b1;
    repeat (WAKE_CYC - 25) @(posedge core_clk);
    #1;
    chk("ready", 40'h0, 40'(ready));
    wait_ready(100);
    chk_out('0, '0);
    // Bytes sent while asleep must not have reached the input word
    m.update();
    rises(FREQ_LAT_CYC);
    chk_out(act, act);
    $display("power-down done");
    run_update(5);
    test_done();
  end
endmodule
